// ===== rtl/slod_pkg.sv
// package for the serial latched output driver
// assumes one system clock; link pins arrive asynchronous and are synchronised
package slod_pkg;
  localparam int unsigned width = 8;
  localparam int unsigned last_stage = width - 1;
  localparam logic [width-1:0] zero_byte = 8'h00;
  localparam logic sync_reset_bit = 1'h0;
  localparam logic clear_n_reset_bit = 1'h0;
  localparam logic enable_n_reset_bit = 1'h1;

  // the five pins from the host, kept together
  typedef struct packed {
    logic shift_clock;
    logic latch_clock;
    logic shift_clear_n;
    logic output_enable_n;
    logic serial_in;
  } slod_pins_s;

  localparam slod_pins_s pins_reset = '{
    shift_clock: sync_reset_bit,
    latch_clock: sync_reset_bit,
    shift_clear_n: clear_n_reset_bit,
    output_enable_n: enable_n_reset_bit,
    serial_in: sync_reset_bit
  };
endpackage : slod_pkg

// ===== rtl/slod_sync.sv
// two-stage synchroniser for the host pin bundle
// assumes pins are asynchronous to clock; stage one is read only by stage two
module slod_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire slod_pkg::slod_pins_s pins_async,
  output slod_pkg::slod_pins_s pins_sync
);
  typedef struct packed {
    slod_pkg::slod_pins_s meta;
    slod_pkg::slod_pins_s sync;
  } slod_sync_state_s;

  slod_sync_state_s state_reg;
  slod_sync_state_s state_next;

  // shift the bundle through two flops
  always_comb begin
    state_next = state_reg;
    if (clock_en) begin
      state_next.meta = pins_async;
      state_next.sync = state_reg.meta;
    end
  end

  // clear sits inactive-safe at reset: clear asserted, outputs disabled
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '{meta: slod_pkg::pins_reset, sync: slod_pkg::pins_reset};
    end else begin
      state_reg <= state_next;
    end
  end

  assign pins_sync = state_reg.sync;
endmodule : slod_sync

// ===== rtl/slod_driver.sv
// serial latched output driver: shift chain, storage register, gated sinks
// assumes host pins are asynchronous and slower than the 20 MHz clock;
// host pin edges are found after a two-flop synchroniser
module slod_driver (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic shift_clock,
  input wire logic latch_clock,
  input wire logic shift_clear_n,
  input wire logic output_enable_n,
  input wire logic serial_in,
  output logic serial_cascade_out,
  output logic [slod_pkg::width-1:0] sink_out
);
  typedef struct packed {
    logic shift_clock_prev;
    logic latch_clock_prev;
    logic [slod_pkg::width-1:0] chain;
    logic [slod_pkg::width-1:0] store;
    logic [slod_pkg::width-1:0] sink;
    logic cascade;
  } slod_state_s;

  slod_pkg::slod_pins_s pins_async;
  slod_pkg::slod_pins_s pins;
  slod_state_s state_reg;
  slod_state_s state_next;
  logic [slod_pkg::width-1:0] chain_shifted;
  logic [slod_pkg::width-1:0] store_now;

  // bundle the host pins for the synchroniser
  assign pins_async = '{
    shift_clock: shift_clock,
    latch_clock: latch_clock,
    shift_clear_n: shift_clear_n,
    output_enable_n: output_enable_n,
    serial_in: serial_in
  };

  slod_sync u_sync (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .pins_async(pins_async),
    .pins_sync(pins)
  );

  // serial in enters stage zero, everything moves one stage up
  generate
    for (genvar i = 1; i < slod_pkg::width; i++) begin : g_chain
      assign chain_shifted[i] = state_reg.chain[i-1];
    end
  endgenerate
  assign chain_shifted[0] = pins.serial_in;

  // next state: edge detection, chain, store, gated sinks
  always_comb begin
    state_next = state_reg;
    store_now = state_reg.store;
    if (clock_en) begin
      state_next.shift_clock_prev = pins.shift_clock;
      state_next.latch_clock_prev = pins.latch_clock;
      // latch copies the chain as it stood before a coincident shift
      if (pins.latch_clock && !state_reg.latch_clock_prev) begin
        store_now = state_reg.chain;
      end
      // clear also empties the store so reset by clear is complete
      if (!pins.shift_clear_n) begin
        state_next.chain = slod_pkg::zero_byte;
        store_now = slod_pkg::zero_byte;
      end else if (pins.shift_clock && !state_reg.shift_clock_prev) begin
        state_next.chain = chain_shifted;
      end
      state_next.store = store_now;
      // one in a sink bit turns that transistor on
      if (pins.output_enable_n || !pins.shift_clear_n) begin
        state_next.sink = slod_pkg::zero_byte;
      end else begin
        state_next.sink = store_now;
      end
      state_next.cascade = state_next.chain[slod_pkg::last_stage];
    end
  end

  // one register for all state; outputs off until the host acts
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= '{
        shift_clock_prev: slod_pkg::sync_reset_bit,
        latch_clock_prev: slod_pkg::sync_reset_bit,
        chain: slod_pkg::zero_byte,
        store: slod_pkg::zero_byte,
        sink: slod_pkg::zero_byte,
        cascade: slod_pkg::sync_reset_bit
      };
    end else begin
      state_reg <= state_next;
    end
  end

  assign serial_cascade_out = state_reg.cascade;
  assign sink_out = state_reg.sink;
endmodule : slod_driver

// ===== tb/slod_host.sv
// host model pacing the five driver pins
// assumes calls start on a falling clock edge
module slod_host (
  input wire logic clock,
  output slod_pkg::slod_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = slod_pkg::pins_reset; // start in clear
  // three clocks per level, else the synchroniser may miss it
  task automatic hold(input int n);
    repeat (3 * n) @(negedge clock);
  endtask : hold
  // far bit first, one latch after all bits
  task automatic load(input logic [7:0] d, input logic lat);
    for (int i = 7; i >= 0; i--) begin
      pins.serial_in = d[i];
      pins.shift_clock = 1'h1;
      hold(1);
      pins.shift_clock = 1'h0;
      hold(1);
    end
    pins.serial_in = ~d[0];
    pins.latch_clock = lat;
    hold(1);
    pins.latch_clock = 1'h0; // read only once latch is low
    hold(2);
  endtask : load
  // enable may be pulsed for dimming
  task automatic set(input logic clr_n, input logic oe_n);
    pins.shift_clear_n = clr_n;
    pins.output_enable_n = oe_n;
    hold(2);
  endtask : set
endmodule : slod_host

// ===== tb/slod_driver_asserts.sv
// port checker for the output driver
// assumes clock_en is held high
module slod_driver_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic shift_clock,
  input wire logic latch_clock,
  input wire logic shift_clear_n,
  input wire logic output_enable_n,
  input wire logic serial_in,
  input wire logic serial_cascade_out,
  input wire logic [slod_pkg::width-1:0] sink_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic quiet;
  // pins settle within three edges, so windows span four or five
  assign quiet = !shift_clock && !output_enable_n && shift_clear_n;
  off_disabled_a: assert property (output_enable_n[*4] |-> sink_out == 8'h00)
    else $error("sink on while disabled");
  off_cleared_a: assert property ((!shift_clear_n)[*4] |-> sink_out == 8'h00)
    else $error("sink on in clear");
  chain_cleared_a: assert property ((!shift_clear_n)[*4] |-> !serial_cascade_out)
    else $error("chain kept in clear");
  store_hold_a: assert property ((!latch_clock && quiet)[*5] |-> $stable(sink_out))
    else $error("store moved");
  cascade_hold_a: assert property ((!shift_clock && shift_clear_n)[*5] |-> $stable(serial_cascade_out))
    else $error("cascade moved");
  latch_copy_a: assert property ((quiet && $rose(latch_clock)) ##1 quiet[*4] |-> sink_out[7] == serial_cascade_out)
    else $error("store not chain");
  clear_gate_a: assert property (sink_out != 8'h00 |-> $past(shift_clear_n, 3))
    else $error("sink on after clear");
  enable_off_a: assert property ($rose(output_enable_n) |-> ##[1:4] sink_out == 8'h00)
    else $error("slow disable");
  cover property ($rose(latch_clock));
  cover property (output_enable_n[*4]);
  cover property ((!shift_clear_n)[*4]);
endmodule : slod_driver_asserts
bind slod_driver slod_driver_asserts u_chk (.*);

// ===== tb/tb.sv
// self-checking bench for the output driver
// assumes the host model paces every pin
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define chk(n, e, g) cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("unexpected %s %h %h", n, e, g); end
  logic clock = 1'h0;
  logic rst = 1'h1;
  int error_cnt = 0;
  int cmp_count = 0;
  logic serial_cascade_out;
  logic [slod_pkg::width-1:0] sink_out;
  slod_pkg::slod_pins_s pins;
  always #25 clock = ~clock;
  slod_host u_slod_host (.clock(clock), .pins(pins));
  slod_driver u_slod_driver (.clock(clock), .rst(rst), .clock_en(1'h1), .shift_clock(pins.shift_clock),
    .latch_clock(pins.latch_clock), .shift_clear_n(pins.shift_clear_n), .output_enable_n(pins.output_enable_n),
    .serial_in(pins.serial_in), .serial_cascade_out(serial_cascade_out), .sink_out(sink_out));
  // verdict in one place
  task automatic conclude;
    $display("mismatches %0d of %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // full byte then latch
  task automatic t_load;
    u_slod_host.set(1'h1, 1'h0);
    u_slod_host.load(8'ha5, 1'h1);
    `chk("sink", 8'ha5, sink_out)
    `chk("cascade", 1'h1, serial_cascade_out)
    $display("load done");
  endtask : t_load
  // shift without latch, then blank and restore
  task automatic t_hold;
    u_slod_host.load(8'h3c, 1'h0);
    `chk("sink", 8'ha5, sink_out)
    `chk("cascade", 1'h0, serial_cascade_out)
    u_slod_host.set(1'h1, 1'h1);
    `chk("sink", 8'h00, sink_out)
    u_slod_host.set(1'h1, 1'h0);
    `chk("sink", 8'ha5, sink_out)
    $display("hold done");
  endtask : t_hold
  // clear empties chain and store
  task automatic t_clear;
    u_slod_host.set(1'h0, 1'h0);
    `chk("sink", 8'h00, sink_out)
    `chk("cascade", 1'h0, serial_cascade_out)
    u_slod_host.set(1'h1, 1'h0);
    `chk("sink", 8'h00, sink_out)
    $display("clear done");
  endtask : t_clear
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock) rst = 1'h0;
    repeat (3) @(negedge clock);
    t_load();
    t_hold();
    t_clear();
    conclude();
  end
  // about 150 clocks expected
  initial begin
    #60000;
    error_cnt++;
    conclude();
  end
endmodule : tb
